// ==== rvfg_ramp_vf.sv ====
`default_nettype none
// Operation
// - accel and decel shapes chosen separately: 0 linear, 1 S-curve
// - linear shape moves frequency at constant rate toward target
// - S-curve shape eases rate in and out
// - start gradient 1-100 percent sets easing-in share, default 40
// - end gradient 1-100 percent sets easing-out share, default 40
// - S-curve accel time is time times one plus gradients over 200
// - S-curve decel time is time times one plus gradients over 200
// - max-referenced ramps below max frequency may cut the curve top
// - input with function 24 active freezes output frequency
// - terminal functions 0-27; three basic terminals, five extended
// - curve 0: voltage proportional to frequency
// - curve 1: voltage proportional to frequency squared
// - curve 2: user points, first at 15.00 Hz, volts 0-100 percent
// - rated voltage at base frequency, 30.00-400.00 Hz, default 60.00
// - no voltage below start frequency, 0.10-10.00 Hz, default 0.50
// - user curve gets no torque boost
// - voltage setting is base-frequency voltage: 0 or 170-264 V
// - above base frequency voltage limited to lower input voltage
// - setting 0 derives voltage from the input voltage
// - time unit 0.01, 0.1 or 1 s by scale setting 0, 1, 2
// - reference 1 measures ramp time over the frequency change
module rvfg_ramp_vf #(
  parameter int unsigned TICK_CYCLES = rvfg_pkg::TICK_CYC
) (
  // clock and control
  input  wire logic                                        ref_clk,
  input  wire logic                                        reset,
  input  wire logic                                        ce,
  // ramp settings
  input  wire logic                                        accelShapeSelect,
  input  wire logic                                        decelShapeSelect,
  input  wire logic [rvfg_pkg::GW-1:0]                     scurveStartGradient,
  input  wire logic [rvfg_pkg::GW-1:0]                     scurveEndGradient,
  input  wire logic [15:0]                                 accelTime,
  input  wire logic [15:0]                                 decelTime,
  input  wire logic [1:0]                                  rampTimeScale,
  input  wire logic                                        rampReferenceSelect,
  input  wire logic [rvfg_pkg::FW-1:0]                     maxFrequency,
  input  wire logic [rvfg_pkg::FW-1:0]                     targetFrequency,
  // digital input terminals
  input  wire logic [rvfg_pkg::NTERM-1:0]                  digitalInput,
  input  wire logic [rvfg_pkg::NTERM-1:0][4:0]             inputFunction,
  input  wire logic                                        extendedIo,
  // voltage curve settings
  input  wire logic [rvfg_pkg::FW-1:0]                     baseFrequency,
  input  wire logic [rvfg_pkg::FW-1:0]                     startFrequency,
  input  wire logic [1:0]                                  voltageCurveSelect,
  input  wire logic [rvfg_pkg::NPTS-1:0][rvfg_pkg::FW-1:0] userPointFreq,
  input  wire logic [rvfg_pkg::NPTS-1:0][rvfg_pkg::GW-1:0] userPointVolt,
  input  wire logic [rvfg_pkg::SW-1:0]                     outputVoltageSetting,
  input  wire logic [rvfg_pkg::VW-1:0]                     inputVoltage,
  // power stage command and status
  output logic      [rvfg_pkg::FW-1:0]                     outFrequency,
  output logic      [rvfg_pkg::VW-1:0]                     outVoltage,
  output logic                                             rampBusy,
  output logic                                             rampHold
);
  localparam int TW = rvfg_pkg::TW;
  localparam int AW = rvfg_pkg::AW;
  localparam int WW = rvfg_pkg::WW;
  localparam int FW = rvfg_pkg::FW;
  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYCLES - 1);

  typedef enum logic [1:0] {RP_IDLE, RP_EASE_IN, RP_CRUISE, RP_EASE_OUT} rvfg_phase_e;

  // ---------------------------------------------------------------
  // control tick
  // ---------------------------------------------------------------
  logic [CW-1:0] tickCnt_reg;
  logic          tick;

  assign tick = (tickCnt_reg == TICK_LAST);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tickCnt_reg <= '0;
    end else if (ce) begin
      tickCnt_reg <= tick ? '0 : tickCnt_reg + CW'(1);
    end
  end

  // ---------------------------------------------------------------
  // terminal decode
  // ---------------------------------------------------------------
  function automatic logic isHold(input logic [4:0] fn);
    return fn == rvfg_pkg::FN_HOLD;
  endfunction

  logic [rvfg_pkg::NTERM-1:0] termHold;
  logic                       holdActive;

  // upper terminals exist only on the extended variant
  for (genvar i = 0; i < rvfg_pkg::NTERM; i++) begin : g_term
    if (i < rvfg_pkg::NBASIC) begin : g_basic
      assign termHold[i] = digitalInput[i] && isHold(inputFunction[i]);
    end else begin : g_ext
      assign termHold[i] = extendedIo && digitalInput[i] && isHold(inputFunction[i]);
    end
  end

  assign holdActive = |termHold;
  assign rampHold   = holdActive;

  // ---------------------------------------------------------------
  // ramp setup
  // ---------------------------------------------------------------
  logic                 rampUp;
  logic                 rampShape;
  logic [15:0]          timeSet;
  logic [TW-1:0]        unitTicks;
  logic [TW-1:0]        rampTicks;
  logic [FW-1:0]        span;
  logic [TW+6:0]        tsProd;
  logic [TW+6:0]        teProd;
  logic [TW-1:0]        tsTicks;
  logic [TW-1:0]        teTicks;
  logic                 rampStart;
  logic [FW-1:0]        goal_reg;

  assign rampStart = (targetFrequency != goal_reg) && !holdActive;

  always_comb begin
    rampUp    = targetFrequency > outFrequency;
    rampShape = rampUp ? accelShapeSelect : decelShapeSelect;
    timeSet   = rampUp ? accelTime : decelTime;
    case (rampTimeScale)
      rvfg_pkg::SCALE_10MS:  unitTicks = rvfg_pkg::TK_10MS;
      rvfg_pkg::SCALE_100MS: unitTicks = rvfg_pkg::TK_100MS;
      rvfg_pkg::SCALE_1S:    unitTicks = rvfg_pkg::TK_1S;
      default:               unitTicks = rvfg_pkg::TK_100MS;
    endcase
    rampTicks = TW'(timeSet) * unitTicks;
    if (rampTicks == '0) begin
      rampTicks = TW'(1);
    end
    // a max-referenced ramp is sized for the full range and simply
    // stops at a lower target, cutting off the top of the S-curve
    if (rampReferenceSelect == rvfg_pkg::REF_DELTA) begin
      span = rampUp ? targetFrequency - outFrequency : outFrequency - targetFrequency;
    end else begin
      span = maxFrequency;
    end
    if (span == '0) begin
      span = FW'(1);
    end
    tsProd  = (TW+7)'(rampTicks) * (TW+7)'(scurveStartGradient);
    teProd  = (TW+7)'(rampTicks) * (TW+7)'(scurveEndGradient);
    tsTicks = TW'(tsProd / (TW+7)'(rvfg_pkg::PCT_FULL));
    teTicks = TW'(teProd / (TW+7)'(rvfg_pkg::PCT_FULL));
    if (tsTicks == '0) begin
      tsTicks = TW'(1);
    end
    if (teTicks == '0) begin
      teTicks = TW'(1);
    end
  end

  logic          dirUp_reg;
  logic [FW-1:0] span_reg;
  logic [AW-1:0] thresh_reg;
  logic [TW-1:0] ts_reg;
  logic [TW-1:0] te_reg;
  logic [TW-1:0] cruise_reg;

  // easing each end by a share g of the ramp stretches it by g/2,
  // which gives the documented S-curve duration
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      goal_reg   <= '0;
      dirUp_reg  <= 1'b0;
      span_reg   <= FW'(1);
      thresh_reg <= AW'(rvfg_pkg::WMAX);
      ts_reg     <= TW'(1);
      te_reg     <= TW'(1);
      cruise_reg <= '0;
    end else if (ce && rampStart) begin
      goal_reg   <= targetFrequency;
      dirUp_reg  <= rampUp;
      span_reg   <= span;
      thresh_reg <= AW'(rampTicks) * AW'(rvfg_pkg::WMAX);
      ts_reg     <= tsTicks;
      te_reg     <= teTicks;
      cruise_reg <= rampTicks - (tsTicks >> 1) - (teTicks >> 1);
    end
  end

  // ---------------------------------------------------------------
  // ramp phase
  // ---------------------------------------------------------------
  rvfg_phase_e   phase_reg;
  logic [TW-1:0] phaseCnt_reg;
  logic          tickGo;
  logic          endIn;
  logic          endCruise;
  logic          arrived;
  logic          rampShape_reg;

  assign tickGo    = tick && !holdActive;
  assign endIn     = tickGo && phase_reg == RP_EASE_IN && phaseCnt_reg + TW'(1) >= ts_reg;
  assign endCruise = tickGo && phase_reg == RP_CRUISE && rampShape_reg
                     && phaseCnt_reg + TW'(1) >= cruise_reg;
  assign arrived   = outFrequency == goal_reg;
  assign rampBusy  = phase_reg != RP_IDLE;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase_reg     <= RP_IDLE;
      phaseCnt_reg  <= '0;
      rampShape_reg <= 1'b0;
    end else if (ce) begin
      if (rampStart) begin
        rampShape_reg <= rampShape;
        phaseCnt_reg  <= '0;
        phase_reg     <= (rampShape == rvfg_pkg::SHAPE_S) ? RP_EASE_IN : RP_CRUISE;
      end else if (arrived) begin
        phase_reg <= RP_IDLE;
      end else begin
        case (phase_reg)
          RP_EASE_IN: begin
            if (endIn) begin
              phase_reg    <= RP_CRUISE;
              phaseCnt_reg <= '0;
            end else if (tickGo) begin
              phaseCnt_reg <= phaseCnt_reg + TW'(1);
            end
          end
          RP_CRUISE: begin
            if (endCruise) begin
              phase_reg    <= RP_EASE_OUT;
              phaseCnt_reg <= '0;
            end else if (tickGo) begin
              phaseCnt_reg <= phaseCnt_reg + TW'(1);
            end
          end
          RP_EASE_OUT: begin
            if (tickGo && phaseCnt_reg < te_reg) begin
              phaseCnt_reg <= phaseCnt_reg + TW'(1);
            end
          end
          default: phase_reg <= RP_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // rate weight
  // ---------------------------------------------------------------
  logic [WW-1:0] weight_reg;
  logic [TW-1:0] wAcc_reg;

  // the weight climbs WMAX steps over the easing span by a serial
  // DDA between ticks; this avoids a divider per ramp
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      weight_reg <= rvfg_pkg::WMAX;
      wAcc_reg   <= '0;
    end else if (ce) begin
      if (rampStart) begin
        weight_reg <= (rampShape == rvfg_pkg::SHAPE_S) ? '0 : rvfg_pkg::WMAX;
        wAcc_reg   <= '0;
      end else if (endIn || endCruise) begin
        weight_reg <= rvfg_pkg::WMAX;
        wAcc_reg   <= '0;
      end else if (tickGo && (phase_reg == RP_EASE_IN || phase_reg == RP_EASE_OUT)) begin
        wAcc_reg <= wAcc_reg + TW'(rvfg_pkg::WMAX);
      end else if (phase_reg == RP_EASE_IN && wAcc_reg >= ts_reg) begin
        wAcc_reg <= wAcc_reg - ts_reg;
        if (weight_reg < rvfg_pkg::WMAX) begin
          weight_reg <= weight_reg + WW'(1);
        end
      end else if (phase_reg == RP_EASE_OUT && wAcc_reg >= te_reg) begin
        wAcc_reg <= wAcc_reg - te_reg;
        // a floor keeps the ramp moving if rounding leaves some span
        if (weight_reg > rvfg_pkg::WMIN) begin
          weight_reg <= weight_reg - WW'(1);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // output frequency
  // ---------------------------------------------------------------
  logic [AW-1:0] fAcc_reg;
  logic [FW-1:0] outFrequency_reg;

  assign outFrequency = outFrequency_reg;

  // steps of one count, at most one per clock, only toward the goal
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fAcc_reg         <= '0;
      outFrequency_reg <= '0;
    end else if (ce) begin
      if (rampStart) begin
        fAcc_reg <= '0;
      end else if (holdActive) begin
        fAcc_reg <= fAcc_reg;
      end else if (tick && phase_reg != RP_IDLE) begin
        fAcc_reg <= fAcc_reg + AW'(span_reg) * AW'(weight_reg);
      end else if (!arrived && phase_reg != RP_IDLE && fAcc_reg >= thresh_reg) begin
        fAcc_reg <= fAcc_reg - thresh_reg;
        outFrequency_reg <= dirUp_reg ? outFrequency_reg + FW'(1)
                                      : outFrequency_reg - FW'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // voltage curve
  // ---------------------------------------------------------------
  rvfg_vf_curve u_vf (
    .ref_clk              (ref_clk),
    .reset                (reset),
    .ce                   (ce),
    .outFreq              (outFrequency_reg),
    .baseFrequency        (baseFrequency),
    .startFrequency       (startFrequency),
    .voltageCurveSelect   (voltageCurveSelect),
    .userPointFreq        (userPointFreq),
    .userPointVolt        (userPointVolt),
    .outputVoltageSetting (outputVoltageSetting),
    .inputVoltage         (inputVoltage),
    .outVoltage           (outVoltage)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  ce_freeze_a: assert property (@(posedge ref_clk) disable iff (reset)
    !ce |=> $stable(outFrequency_reg) && $stable(weight_reg))
    else $error("state moved with clock enable low");

  hold_freeze_a: assert property (@(posedge ref_clk) disable iff (reset)
    (ce && holdActive) |=> $stable(outFrequency_reg))
    else $error("frequency moved during ramp hold");

  unit_step_a: assert property (@(posedge ref_clk) disable iff (reset)
    (outFrequency_reg != $past(outFrequency_reg)) |->
      (outFrequency_reg == $past(outFrequency_reg) + FW'(1) ||
       outFrequency_reg == $past(outFrequency_reg) - FW'(1)))
    else $error("frequency jumped by more than one count");

  goal_stop_a: assert property (@(posedge ref_clk) disable iff (reset)
    (ce && arrived) |=> $stable(outFrequency_reg))
    else $error("frequency moved past the goal");

  linear_weight_a: assert property (@(posedge ref_clk) disable iff (reset)
    (ce && rampStart && rampShape != rvfg_pkg::SHAPE_S)
      |=> weight_reg == rvfg_pkg::WMAX && phase_reg == RP_CRUISE)
    else $error("linear ramp not at full constant rate");

  scurve_start_a: assert property (@(posedge ref_clk) disable iff (reset)
    (ce && rampStart && rampShape == rvfg_pkg::SHAPE_S)
      |=> weight_reg == '0 && phase_reg == RP_EASE_IN)
    else $error("S-curve ramp did not ease in from zero rate");

endmodule // rvfg_ramp_vf
`default_nettype wire

// ==== rvfg_vf_curve.sv ====
`default_nettype none
// ---------------------------------------------------------------
// shared constants
// ---------------------------------------------------------------
package rvfg_pkg;
  localparam int unsigned CLK_HZ   = 50_000_000;
  // control tick period in microseconds
  localparam int unsigned TICK_US  = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int FW    = 16;  // frequency, 0.01 Hz units
  localparam int TW    = 26;  // ramp length in control ticks
  localparam int WW    = 11;  // ramp rate weight
  localparam int AW    = 40;  // step accumulator
  localparam int VW    = 12;  // voltage, 0.1 V units
  localparam int GW    = 7;   // gradient / point percent
  localparam int SW    = 9;   // output voltage setting, volts
  localparam int NPTS  = 4;
  localparam int NTERM = 5;
  localparam int NBASIC = 3;
  localparam logic [WW-1:0] WMAX    = 11'h400;
  localparam logic [WW-1:0] WMIN    = 11'h001;
  localparam logic [4:0]    FN_HOLD = 5'h18;
  localparam logic          SHAPE_S = 1'b1;
  localparam logic [1:0] SCALE_10MS  = 2'h0;
  localparam logic [1:0] SCALE_100MS = 2'h1;
  localparam logic [1:0] SCALE_1S    = 2'h2;
  localparam logic [TW-1:0] TK_10MS  = TW'(10_000 / TICK_US);
  localparam logic [TW-1:0] TK_100MS = TW'(100_000 / TICK_US);
  localparam logic [TW-1:0] TK_1S    = TW'(1_000_000 / TICK_US);
  localparam logic          REF_DELTA = 1'b1;
  localparam logic [1:0] VF_LIN  = 2'h0;
  localparam logic [1:0] VF_SQ   = 2'h1;
  localparam logic [1:0] VF_USER = 2'h2;
  localparam logic [GW-1:0] PCT_FULL   = 7'h64;
  localparam logic [3:0]    VOLT_SCALE = 4'hA;
endpackage

module rvfg_vf_curve (
  // clock and control
  input  wire logic                                    ref_clk,
  input  wire logic                                    reset,
  input  wire logic                                    ce,
  // operating point and curve settings
  input  wire logic [rvfg_pkg::FW-1:0]                 outFreq,
  input  wire logic [rvfg_pkg::FW-1:0]                 baseFrequency,
  input  wire logic [rvfg_pkg::FW-1:0]                 startFrequency,
  input  wire logic [1:0]                              voltageCurveSelect,
  input  wire logic [rvfg_pkg::NPTS-1:0][rvfg_pkg::FW-1:0] userPointFreq,
  input  wire logic [rvfg_pkg::NPTS-1:0][rvfg_pkg::GW-1:0] userPointVolt,
  input  wire logic [rvfg_pkg::SW-1:0]                 outputVoltageSetting,
  input  wire logic [rvfg_pkg::VW-1:0]                 inputVoltage,
  // power stage voltage command
  output logic      [rvfg_pkg::VW-1:0]                 outVoltage
);
  localparam int NW = 48;

  logic [rvfg_pkg::VW-1:0] ratedVolt;
  logic [rvfg_pkg::VW-1:0] ratedAbove;
  logic [rvfg_pkg::FW-1:0] segLoF;
  logic [rvfg_pkg::FW-1:0] segHiF;
  logic [rvfg_pkg::VW-1:0] segLoV;
  logic [rvfg_pkg::VW-1:0] segHiV;
  logic [NW-1:0]           num;
  logic [NW-1:0]           den;
  logic [NW-1:0]           quo;
  logic                    falling;
  logic [rvfg_pkg::VW-1:0] curveV;
  logic [rvfg_pkg::VW-1:0] outVoltage_next;

  function automatic logic [rvfg_pkg::VW-1:0] pctVolt(
    input logic [rvfg_pkg::VW-1:0] rated,
    input logic [rvfg_pkg::GW-1:0] pct);
    logic [rvfg_pkg::VW+6:0] prod;
    prod = (rvfg_pkg::VW+7)'(rated) * (rvfg_pkg::VW+7)'(pct);
    return rvfg_pkg::VW'(prod / (rvfg_pkg::VW+7)'(rvfg_pkg::PCT_FULL));
  endfunction

  // zero setting follows the supply instead of a fixed value
  always_comb begin
    if (outputVoltageSetting == '0) begin
      ratedVolt = inputVoltage;
    end else begin
      ratedVolt = rvfg_pkg::VW'(outputVoltageSetting) * rvfg_pkg::VW'(rvfg_pkg::VOLT_SCALE);
    end
    ratedAbove = (inputVoltage < ratedVolt) ? inputVoltage : ratedVolt;
  end

  // bracketing points; points are assumed to be set in ascending order
  always_comb begin
    segLoF = '0;
    segLoV = '0;
    segHiF = baseFrequency;
    segHiV = ratedVolt;
    for (int i = 0; i < rvfg_pkg::NPTS; i++) begin
      if (outFreq >= userPointFreq[i]) begin
        segLoF = userPointFreq[i];
        segLoV = pctVolt(ratedVolt, userPointVolt[i]);
      end
    end
    for (int i = rvfg_pkg::NPTS - 1; i >= 0; i--) begin
      if (outFreq < userPointFreq[i]) begin
        segHiF = userPointFreq[i];
        segHiV = pctVolt(ratedVolt, userPointVolt[i]);
      end
    end
  end

  // one shared divider serves all three curve shapes
  always_comb begin
    falling = 1'b0;
    case (voltageCurveSelect)
      rvfg_pkg::VF_SQ: begin
        num = NW'(ratedVolt) * NW'(outFreq) * NW'(outFreq);
        den = NW'(baseFrequency) * NW'(baseFrequency);
      end
      rvfg_pkg::VF_USER: begin
        falling = segHiV < segLoV;
        num = NW'(falling ? segLoV - segHiV : segHiV - segLoV) * NW'(outFreq - segLoF);
        den = NW'(segHiF - segLoF);
      end
      default: begin
        num = NW'(ratedVolt) * NW'(outFreq);
        den = NW'(baseFrequency);
      end
    endcase
    quo = (den == '0) ? '0 : num / den;
    if (voltageCurveSelect == rvfg_pkg::VF_USER) begin
      curveV = falling ? segLoV - rvfg_pkg::VW'(quo) : segLoV + rvfg_pkg::VW'(quo);
    end else begin
      curveV = rvfg_pkg::VW'(quo);
    end
  end

  // no torque boost term is ever added, so the user curve stays unboosted
  always_comb begin
    if (outFreq < startFrequency) begin
      outVoltage_next = '0;
    end else if (outFreq >= baseFrequency) begin
      outVoltage_next = ratedAbove;
    end else begin
      outVoltage_next = (curveV > ratedVolt) ? ratedVolt : curveV;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      outVoltage <= '0;
    end else if (ce) begin
      outVoltage <= outVoltage_next;
    end
  end

  below_start_a: assert property (@(posedge ref_clk) disable iff (reset)
    (ce && outFreq < startFrequency) |=> outVoltage == '0)
    else $error("voltage driven below start frequency");

  above_base_a: assert property (@(posedge ref_clk) disable iff (reset)
    (ce && outFreq >= baseFrequency && outFreq >= startFrequency)
      |=> outVoltage == $past(ratedAbove))
    else $error("voltage above base frequency not limited");

  rated_cap_a: assert property (@(posedge ref_clk) disable iff (reset)
    ce |=> outVoltage <= $past(ratedVolt))
    else $error("voltage exceeds rated setting");

endmodule // rvfg_vf_curve
`default_nettype wire

// ==== rvfg_motor_model.sv ====
`default_nettype none
// ------------------------------------------
// induction motor fed by the power stage
// ------------------------------------------
module rvfg_motor_model (
  // stator drive
  input  wire logic        ref_clk,
  input  wire logic [15:0] statorFreq,
  input  wire logic [11:0] statorVolt,
  // shaft
  output logic      [15:0] rotorFreq
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rotorFreq = 16'h0000;
  // unexcited rotor coasts down; excited rotor runs with a fixed slip
  always @(posedge ref_clk) begin
    if (statorVolt != 12'h000) rotorFreq <= statorFreq - (statorFreq >> 5);
    else if (rotorFreq != 16'h0000) rotorFreq <= rotorFreq - 16'h0001;
  end
endmodule // rvfg_motor_model
`default_nettype wire

// ==== rvfg_ramp_vf_bench.sv ====
`default_nettype none
module rvfg_ramp_vf_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 1500;
  logic ref_clk = 1'b0, reset = 1'b1, aSh = 1'b0, dSh = 1'b0, ext = 1'b0;
  logic ce = 1'b1, refSel = 1'b1;
  logic [6:0] grad = 7'h28;
  logic [15:0] rTime = 16'h0001;
  logic [1:0] scale = 2'h0;
  logic [15:0] target = 16'h0000;
  logic [4:0] din = 5'h00;
  logic [4:0][4:0] fn = '0;
  logic [1:0] vcs = 2'h0;
  logic [8:0] ovs = 9'h0DC;
  logic [11:0] vin = 12'hBB8;
  logic [15:0] freq, rotor;
  logic [11:0] volt;
  logic busy, hold;
  int nFail = 0, numChecks = 0, tk;
  always #10 ref_clk = ~ref_clk;
  rvfg_ramp_vf #(.TICK_CYCLES(TK)) dut (.ref_clk(ref_clk), .reset(reset), .ce(ce),
    .accelShapeSelect(aSh), .decelShapeSelect(dSh), .scurveStartGradient(grad),
    .scurveEndGradient(grad), .accelTime(rTime), .decelTime(rTime),
    .rampTimeScale(scale), .rampReferenceSelect(refSel), .maxFrequency(16'h1770),
    .targetFrequency(target), .digitalInput(din), .inputFunction(fn), .extendedIo(ext),
    .baseFrequency(16'h0064), .startFrequency(16'h0032), .voltageCurveSelect(vcs),
    .userPointFreq({16'h0050, 16'h0040, 16'h0030, 16'h0020}),
    .userPointVolt({7'h50, 7'h40, 7'h30, 7'h20}), .outputVoltageSetting(ovs),
    .inputVoltage(vin), .outFrequency(freq), .outVoltage(volt), .rampBusy(busy),
    .rampHold(hold));
  rvfg_motor_model partner (.ref_clk(ref_clk), .statorFreq(freq), .statorVolt(volt),
    .rotorFreq(rotor));
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // ramp time in whole ticks, first tick may be partial
  task automatic ramp(logic [15:0] tgt);
    int n;
    n = 0;
    @(posedge ref_clk) target <= tgt;
    repeat (2) @(posedge ref_clk);
    #1;
    while (busy === 1'b1 && n < 40 * TK) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    tk = n / TK;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #1800000;
    nFail++;
    give_verdict();
  end
  initial begin
    fn[4] = 5'h18;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk) din <= 5'h10;
    #1;
    chk("volt", 16'(volt), 16'h0000);
    chk("hold", 16'(hold), 16'h0000);
    @(posedge ref_clk) ext <= 1'b1;
    target <= 16'h0064;
    repeat (3 * TK) @(posedge ref_clk);
    #1;
    chk("hold", 16'(hold), 16'h0001);
    chk("freq", freq, 16'h0000);
    @(posedge ref_clk) din <= 5'h00;
    ce <= 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    chk("busy", 16'(busy), 16'h0000);
    chk("freq", freq, 16'h0000);
    @(posedge ref_clk) ce <= 1'b1;
    $display("test done: hold");
    ramp(16'h0064);
    chk("freq", freq, 16'h0064);
    chk("ticks", 16'(tk >= 9 && tk <= 11), 16'h0001);
    for (int c = 0; c < 3; c++) begin
      @(posedge ref_clk) vcs <= 2'(c);
      repeat (3) @(posedge ref_clk);
      #1;
      chk("volt", 16'(volt), 16'h0898);
    end
    @(posedge ref_clk) vin <= 12'h3E8;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("volt", 16'(volt), 16'h03E8);
    @(posedge ref_clk) ovs <= 9'h000;
    vin <= 12'h7D0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("volt", 16'(volt), 16'h07D0);
    $display("test done: linear and voltage");
    aSh <= 1'b1;
    ramp(16'h00C8);
    chk("freq", freq, 16'h00C8);
    chk("ticks", 16'(tk >= 13 && tk <= 15), 16'h0001);
    dSh <= 1'b1;
    ramp(16'h0000);
    chk("freq", freq, 16'h0000);
    chk("ticks", 16'(tk >= 13 && tk <= 15), 16'h0001);
    $display("test done: s-curve");
    give_verdict();
  end
endmodule // rvfg_ramp_vf_bench
`default_nettype wire
